// ==== shared/beacon_pkg.sv ====
// Constants, register map and state types of the directed beacon engine.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package beacon_pkg;
    localparam int APB_AW = 10;
    localparam int CLK_NS = 10;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_NS;
    localparam int PRE_W = $clog2(CYC_PER_US);
    localparam logic [23:0] PERIOD_US = 24'h010000;
    localparam int TX_BUF_BYTES = 200;
    localparam int LOG_BUF_BYTES = 512;
    localparam int LOG_ENTRY_BYTES = 16;
    localparam int FTYPE_LSB = 3;

    localparam logic [APB_AW-1:0] OFF_CTRL_SET = 10'h000;
    localparam logic [APB_AW-1:0] OFF_CTRL_CLR = 10'h004;
    localparam logic [APB_AW-1:0] OFF_STATUS = 10'h008;
    localparam logic [APB_AW-1:0] OFF_CHAN_TIME = 10'h00C;
    localparam logic [APB_AW-1:0] OFF_TX_PARAMS = 10'h010;
    localparam logic [APB_AW-1:0] OFF_TX_ADJ_IE = 10'h014;
    localparam logic [APB_AW-1:0] OFF_TX_LEN = 10'h018;
    localparam logic [APB_AW-1:0] OFF_RX_START = 10'h01C;
    localparam logic [APB_AW-1:0] OFF_RX_END = 10'h020;
    localparam logic [APB_AW-1:0] OFF_RX_CFG = 10'h024;
    localparam logic [APB_AW-1:0] OFF_INT_STAT = 10'h028;
    localparam logic [APB_AW-1:0] OFF_INT_MASK = 10'h02C;
    localparam logic [APB_AW-1:0] OFF_TXBUF = 10'h100;
    localparam logic [APB_AW-1:0] OFF_LOG = 10'h200;

    localparam int F_TX = 0;
    localparam int F_CNT = 1;
    localparam int EV_TX = 0;
    localparam int EV_DONE = 1;
    localparam int EV_FULL = 2;
    localparam int EV_PKT = 3;

    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;

    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_FCS} txs_t;
endpackage

// ==== hw/fcs_crc32.sv ====
// Byte-serial CRC-32 generator for the outgoing frame check sequence.
`timescale 1ns/1ps
module fcs_crc32 (
    input wire logic clk, // Core clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic init, // Preset the remainder.
    input wire logic en, // Fold in one byte.
    input wire logic [7:0] data, // Byte to fold in.
    output logic [31:0] crc_q, // Registered remainder.
    output logic [31:0] crc_nxt // Remainder with the current byte folded in.
);
    import beacon_pkg::*;

    typedef struct packed {
        logic [31:0] crc;
    } cst_t;

    cst_t s;
    cst_t n;

    function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r >> 1) ^ (((r[0] ^ d[i]) == 1'b1) ? CRC_POLY : 32'h00000000);
        end
        return r;
    endfunction

    always_comb begin
        n = s;
        crc_nxt = step(s.crc, data);
        if (init) begin
            n.crc = CRC_INIT;
        end else if (en) begin
            n.crc = crc_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s.crc <= CRC_INIT;
        end else begin
            s <= n;
        end
    end

    assign crc_q = s.crc;
endmodule

// ==== hw/directed_beacon_txrx.sv ====
// Directed beacon engine: timed packet send, filtered packet logging, APB registers.
`timescale 1ns/1ps
module directed_beacon_txrx #(
    parameter int TX_BYTES = beacon_pkg::TX_BUF_BYTES,
    parameter int LOG_BYTES = beacon_pkg::LOG_BUF_BYTES
) (
    input wire logic CORE_CLK, // Core clock, 100 MHz.
    input wire logic RSTN, // Synchronous reset, active low.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB access phase.
    input wire logic PWRITE, // APB direction.
    input wire logic [beacon_pkg::APB_AW-1:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    output logic [31:0] PRDATA, // APB read data.
    output logic PREADY, // APB ready.
    output logic PSLVERR, // APB error on unmapped address.
    output logic TX_VALID, // Transmit byte valid.
    input wire logic TX_READY, // Radio takes the byte.
    output logic [7:0] TX_DATA, // Transmit byte.
    output logic TX_LAST, // Last byte of the frame.
    output logic RX_ENABLE, // Receiver on during the window.
    output logic [7:0] RX_CHANNEL, // Radio channel to listen on.
    input wire logic RX_SOP, // Preamble start pulse.
    input wire logic RX_HDR_OK, // Header received correctly, pulse.
    input wire logic [47:0] RX_HDR, // Leading six header bytes.
    input wire logic [7:0] RX_LQI, // Link quality value of the packet.
    input wire logic DEV_SLEEP, // Device asleep.
    input wire logic DEV_AUTH, // Device authenticated.
    output logic IRQ // Level interrupt.
);
    import beacon_pkg::*;

    localparam int ENTRIES = LOG_BYTES / LOG_ENTRY_BYTES;
    localparam int EW = $clog2(ENTRIES);
    localparam int CW = $clog2(ENTRIES + 1);
    localparam int TLW = $clog2(TX_BYTES + 1);
    localparam int TX_WORDS = (TX_BYTES + 3) / 4;

    typedef struct packed {
        logic tx_en;
        logic cnt_en;
        logic rx_act;
        logic full;
        logic auth_d;
        logic tick_d;
        logic pend;
        logic [PRE_W-1:0] pre;
        logic [23:0] ct;
        logic [23:0] tx_start;
        logic [7:0] adj;
        logic [7:0] adj_pend;
        logic [23:0] next_t;
        logic [TLW-1:0] tx_len;
        logic [23:0] rx_start;
        logic [23:0] rx_end;
        logic [7:0] chan;
        logic [7:0] filt;
        logic [23:0] sop_t;
        logic [CW-1:0] cnt;
        logic [3:0] ist;
        logic [3:0] imask;
        txs_t txs;
        logic [TLW-1:0] idx;
        logic [1:0] fidx;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic [31:0] prdata;
        logic pslverr;
    } st_t;

    st_t s;
    st_t n;
    logic [7:0] tx_mem [TX_BYTES];
    logic [95:0] log_mem [ENTRIES];

    logic tx_hit, rx_start_hit, rx_end_hit, setup, wr, pass, log_we, tx_wr;
    logic in_log, in_txb, crc_init, crc_en;
    logic [7:0] crc_byte;
    logic [1:0] fidx_n;
    logic [3:0] ev, clr;
    logic [95:0] log_wdata, log_rd;
    logic [31:0] crc_q, crc_nxt;
    logic [APB_AW-1:0] log_off, tx_off;

    function automatic logic [23:0] next_time(input logic [23:0] now, input logic [7:0] a);
        return now + PERIOD_US + {16'h0000, a};
    endfunction

    function automatic logic [7:0] onehot(input logic [2:0] t);
        return 8'h01 << t;
    endfunction

    //------------------------------------------------------------------
    // Address windows
    //------------------------------------------------------------------
    assign log_off = PADDR - OFF_LOG;
    assign tx_off = PADDR - OFF_TXBUF;
    assign in_log = (PADDR >= OFF_LOG) && (int'(log_off) < LOG_BYTES);
    assign in_txb = (PADDR >= OFF_TXBUF) && (int'(tx_off) < 4 * TX_WORDS);
    assign log_rd = log_mem[log_off[EW+3:4]];
    assign pass = |(onehot(RX_HDR[FTYPE_LSB +: 3]) & s.filt);

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    always_comb begin
        n = s;
        setup = PSEL && !PENABLE;
        wr = PSEL && PENABLE && PWRITE;
        tx_wr = wr && in_txb;
        tx_hit = s.tick_d && s.tx_en && (s.ct == s.next_t);
        rx_start_hit = s.tick_d && s.cnt_en && (s.ct == s.rx_start);
        rx_end_hit = s.tick_d && s.cnt_en && (s.ct == s.rx_end);
        crc_init = 1'b0;
        crc_en = 1'b0;
        crc_byte = s.tx_data;
        fidx_n = s.fidx + 2'd1;
        log_we = 1'b0;
        log_wdata = {16'h0000, RX_HDR, RX_LQI, s.sop_t};
        ev = 4'h0;
        n.tick_d = 1'b0;
        n.auth_d = DEV_AUTH;
        // A one-cycle tick after each microsecond keeps every match to a single firing.
        if (s.pre == PRE_W'(CYC_PER_US - 1)) begin
            n.pre = '0;
            n.ct = s.ct + 24'h000001;
            n.tick_d = 1'b1;
        end else begin
            n.pre = s.pre + 1'b1;
        end
        if (RX_SOP) begin
            n.sop_t = s.ct;
        end
        // The adjustment waiting at a send applies only from that send onward.
        if (tx_hit) begin
            ev[EV_TX] = 1'b1;
            if (s.pend) begin
                n.adj = s.adj_pend;
                n.pend = 1'b0;
                n.next_t = next_time(s.ct, s.adj_pend);
            end else begin
                n.next_t = next_time(s.ct, s.adj);
            end
            if (s.txs == TX_IDLE && s.tx_len != '0) begin
                n.txs = TX_SEND;
                n.idx = '0;
                n.tx_valid = 1'b1;
                n.tx_data = tx_mem[0];
                crc_init = 1'b1;
            end
        end
        if (wr) begin
            case (PADDR)
                OFF_CTRL_SET: begin
                    if (PWDATA[F_TX] && !s.tx_en) begin
                        n.tx_en = 1'b1;
                        n.next_t = s.tx_start;
                    end
                    if (PWDATA[F_CNT] && !s.cnt_en) begin
                        n.cnt_en = 1'b1;
                        n.cnt = '0;
                        n.full = 1'b0;
                        n.rx_act = 1'b0;
                    end
                end
                OFF_CTRL_CLR: begin
                    if (PWDATA[F_TX]) begin
                        n.tx_en = 1'b0;
                    end
                    if (PWDATA[F_CNT]) begin
                        n.cnt_en = 1'b0;
                        n.rx_act = 1'b0;
                    end
                end
                OFF_CHAN_TIME: n.ct = PWDATA[23:0];
                OFF_TX_PARAMS: begin
                    n.tx_start = PWDATA[23:0];
                    n.adj = PWDATA[31:24];
                    n.pend = 1'b0;
                end
                OFF_TX_ADJ_IE: begin
                    n.adj_pend = PWDATA[7:0];
                    n.pend = 1'b1;
                end
                OFF_TX_LEN: begin
                    n.tx_len = (PWDATA > 32'(TX_BYTES)) ? TLW'(TX_BYTES) : PWDATA[TLW-1:0];
                end
                OFF_RX_START: n.rx_start = PWDATA[23:0];
                OFF_RX_END: n.rx_end = PWDATA[23:0];
                OFF_RX_CFG: begin
                    n.chan = PWDATA[7:0];
                    n.filt = PWDATA[15:8];
                end
                OFF_INT_MASK: n.imask = PWDATA[3:0];
                default: ;
            endcase
        end
        // A packet already started runs to its end even if sending is disabled.
        case (s.txs)
            TX_SEND: begin
                if (TX_READY) begin
                    crc_en = 1'b1;
                    if (s.idx == s.tx_len - 1'b1) begin
                        n.txs = TX_FCS;
                        n.fidx = 2'd0;
                        n.tx_data = ~crc_nxt[7:0];
                    end else begin
                        n.idx = s.idx + 1'b1;
                        n.tx_data = tx_mem[s.idx + 1'b1];
                    end
                end
            end
            TX_FCS: begin
                if (TX_READY) begin
                    if (s.fidx == 2'd3) begin
                        n.txs = TX_IDLE;
                        n.tx_valid = 1'b0;
                        n.tx_last = 1'b0;
                    end else begin
                        n.fidx = fidx_n;
                        n.tx_data = ~crc_q[{fidx_n, 3'b000} +: 8];
                        n.tx_last = (s.fidx == 2'd2);
                    end
                end
            end
            default: ;
        endcase
        if (rx_start_hit) begin
            n.rx_act = 1'b1;
        end
        if (s.rx_act && RX_HDR_OK && pass && !s.full) begin
            log_we = 1'b1;
            n.cnt = s.cnt + 1'b1;
            ev[EV_PKT] = 1'b1;
            if (s.cnt == CW'(ENTRIES - 1)) begin
                n.full = 1'b1;
                n.cnt_en = 1'b0;
                n.rx_act = 1'b0;
                ev[EV_FULL] = 1'b1;
            end
        end
        if (rx_end_hit) begin
            n.rx_act = 1'b0;
            n.cnt_en = 1'b0;
            ev[EV_DONE] = 1'b1;
        end
        if (DEV_SLEEP || (s.auth_d && !DEV_AUTH)) begin
            n.tx_en = 1'b0;
        end
        // A new event wins over a software clear in the same cycle.
        clr = (wr && PADDR == OFF_INT_STAT) ? PWDATA[3:0] : 4'h0;
        n.ist = (s.ist & ~clr) | ev;
        if (setup) begin
            n.pslverr = 1'b0;
            n.prdata = 32'h00000000;
            case (PADDR)
                OFF_CTRL_SET, OFF_CTRL_CLR: ;
                OFF_STATUS: begin
                    n.prdata = {16'h0000, 8'(s.cnt), 4'h0, s.full, s.rx_act, s.cnt_en, s.tx_en};
                end
                OFF_CHAN_TIME: n.prdata = {8'h00, s.ct};
                OFF_TX_PARAMS: n.prdata = {s.adj, s.tx_start};
                OFF_TX_ADJ_IE: n.prdata = {23'h000000, s.pend, s.adj_pend};
                OFF_TX_LEN: n.prdata = 32'(s.tx_len);
                OFF_RX_START: n.prdata = {8'h00, s.rx_start};
                OFF_RX_END: n.prdata = {8'h00, s.rx_end};
                OFF_RX_CFG: n.prdata = {16'h0000, s.filt, s.chan};
                OFF_INT_STAT: n.prdata = {28'h0000000, s.ist};
                OFF_INT_MASK: n.prdata = {28'h0000000, s.imask};
                default: begin
                    if (in_log) begin
                        case (log_off[3:2])
                            2'd0: n.prdata = log_rd[31:0];
                            2'd1: n.prdata = log_rd[63:32];
                            2'd2: n.prdata = log_rd[95:64];
                            default: n.prdata = 32'h00000000;
                        endcase
                    end else if (!in_txb) begin
                        n.pslverr = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    //------------------------------------------------------------------
    // Storage
    //------------------------------------------------------------------
    // Writing the transmit store while a packet is going out corrupts that packet.
    always_ff @(posedge CORE_CLK) begin
        if (tx_wr) begin
            for (int k = 0; k < 4; k++) begin
                if (4 * int'(tx_off[APB_AW-1:2]) + k < TX_BYTES) begin
                    tx_mem[4 * int'(tx_off[APB_AW-1:2]) + k] <= PWDATA[8*k +: 8];
                end
            end
        end
        if (log_we) begin
            log_mem[s.cnt[EW-1:0]] <= log_wdata;
        end
    end

    fcs_crc32 u_fcs (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .init(crc_init),
        .en(crc_en),
        .data(crc_byte),
        .crc_q(crc_q),
        .crc_nxt(crc_nxt)
    );

    assign PREADY = 1'b1;
    assign PRDATA = s.prdata;
    assign PSLVERR = s.pslverr;
    assign TX_VALID = s.tx_valid;
    assign TX_DATA = s.tx_data;
    assign TX_LAST = s.tx_last;
    assign RX_ENABLE = s.rx_act;
    assign RX_CHANNEL = s.chan;
    assign IRQ = |(s.ist & s.imask);

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    // The radio may stall any byte, so the end mark is tied to the fourth check byte, not a time.
    property p_fcs_end;
        TX_LAST |-> TX_VALID && s.txs == TX_FCS && s.fidx == 2'd3;
    endproperty
    a_fcs_end: assert property (p_fcs_end) else $error("FCS not four bytes");
    property p_hold;
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
    endproperty
    a_hold: assert property (p_hold) else $error("tx byte dropped");
    property p_len;
        int'(s.tx_len) <= TX_BYTES;
    endproperty
    a_len: assert property (p_len) else $error("tx length over store");
    property p_params;
        wr && PADDR == OFF_TX_PARAMS |=> s.tx_start == $past(PWDATA[23:0]) && s.adj == $past(PWDATA[31:24]);
    endproperty
    a_params: assert property (p_params) else $error("tx params not held");
    property p_first;
        tx_hit && s.txs == TX_IDLE && s.tx_len != '0 |=> TX_VALID && s.idx == '0;
    endproperty
    a_first: assert property (p_first) else $error("send missed at match");
    property p_period;
        tx_hit && !s.pend |=> s.next_t == next_time($past(s.ct), $past(s.adj));
    endproperty
    a_period: assert property (p_period) else $error("wrong resend period");
    property p_adj;
        tx_hit && s.pend |=> s.adj == $past(s.adj_pend) && !s.pend;
    endproperty
    a_adj: assert property (p_adj) else $error("adjustment not applied");
    property p_sleep;
        DEV_SLEEP || (s.auth_d && !DEV_AUTH) |=> !s.tx_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("tx stays enabled");
    property p_cfg;
        wr && PADDR == OFF_RX_CFG |=> RX_CHANNEL == $past(PWDATA[7:0]) && s.filt == $past(PWDATA[15:8]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("rx config not held");
    property p_end;
        rx_end_hit |=> !s.cnt_en && !RX_ENABLE && s.ist[EV_DONE];
    endproperty
    a_end: assert property (p_end) else $error("window end ignored");
    property p_start;
        rx_start_hit && !rx_end_hit && !(wr && PADDR == OFF_CTRL_CLR) |=> RX_ENABLE;
    endproperty
    a_start: assert property (p_start) else $error("window start ignored");
    property p_filter;
        log_we |-> s.rx_act && (onehot(RX_HDR[FTYPE_LSB +: 3]) & s.filt) != 8'h00;
    endproperty
    a_filter: assert property (p_filter) else $error("filtered packet logged");
    property p_entry;
        log_we |-> log_wdata[23:0] == s.sop_t && log_wdata[79:32] == RX_HDR;
    endproperty
    a_entry: assert property (p_entry) else $error("log entry wrong");
    property p_full;
        log_we && s.cnt == CW'(ENTRIES - 1) |=> s.full && !s.cnt_en;
    endproperty
    a_full: assert property (p_full) else $error("full log not stopping");
    property p_count;
        log_we |=> s.cnt == $past(s.cnt) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("count not advanced");
    property p_tick;
        s.tick_d && !$past(wr && PADDR == OFF_CHAN_TIME) |-> s.ct == $past(s.ct) + 24'h000001;
    endproperty
    a_tick: assert property (p_tick) else $error("channel time step wrong");

    c_send: cover property (tx_hit ##[1:400] TX_LAST && TX_READY);
    c_adj: cover property (tx_hit && s.pend);
    c_full: cover property (log_we && s.cnt == CW'(ENTRIES - 1));
    c_done: cover property (rx_end_hit && s.cnt != '0);
endmodule

// ==== testbench/radio_sink.sv ====
// Radio-side sink that takes transmit bytes and stalls on alternate cycles.
`timescale 1ns/1ps
module radio_sink (
    input wire logic clk, // Core clock.
    input wire logic tx_valid, // Byte offered.
    input wire logic [7:0] tx_data, // Offered byte.
    input wire logic tx_last, // Last byte of the frame.
    output logic tx_ready // Byte taken at this edge.
);
    logic [7:0] rx_q[$];
    int frames = 0;
    initial tx_ready = 1'b0;
    // Toggling ready makes every byte after the first of a frame meet a stall, so held data is exercised.
    always @(posedge clk) begin
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
            if (tx_last) frames <= frames + 1;
        end
    end
endmodule

// ==== testbench/directed_beacon_txrx_bench.sv ====
// Self-checking bench for the directed beacon engine.
`timescale 1ns/1ps
module directed_beacon_txrx_bench;
    import beacon_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, sop = 0, hok = 0, slp = 0, auth = 1;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, tx_valid, tx_ready, tx_last, rx_en, irq;
    logic [7:0] tx_data, rx_ch, link_quality_value = '0;
    logic [47:0] hdr = '0;
    int mismatches = 0, compares = 0;

    initial forever #5 clk = ~clk;

    directed_beacon_txrx u_directed_beacon_txrx (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .TX_DATA(tx_data), .TX_LAST(tx_last), .RX_ENABLE(rx_en), .RX_CHANNEL(rx_ch),
        .RX_SOP(sop), .RX_HDR_OK(hok), .RX_HDR(hdr), .RX_LQI(link_quality_value), .DEV_SLEEP(slp),
        .DEV_AUTH(auth), .IRQ(irq));
    radio_sink u_radio_sink (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready));

    task automatic wrap_up;
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask

    // Reflected CRC-32 over one little-endian word, bit by bit.
    function automatic logic [31:0] fcs(input logic [31:0] w);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < 32; i++) c = (c[0] ^ w[i]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        return ~c;
    endfunction

    // The 300-cycle bound spans three microseconds, so a send one microsecond late still passes.
    task automatic wait_frames(input int n);
        repeat (300) begin
            @(negedge clk);
            if (u_radio_sink.frames == n) break;
        end
        ck(u_radio_sink.frames, n);
    endtask

    task automatic wait_en(input logic v);
        repeat (400) begin
            @(negedge clk);
            if (rx_en === v) break;
        end
        ck(rx_en, v);
    endtask

    task automatic pkt(input logic [47:0] h, input logic [7:0] q);
        @(posedge clk);
        sop <= 1;
        @(posedge clk);
        sop <= 0;
        hok <= 1;
        hdr <= h;
        link_quality_value <= q;
        @(posedge clk);
        hok <= 0;
        hdr <= ~h;
        link_quality_value <= ~q;
    endtask

    task automatic t_tx;
        apb(1, OFF_TXBUF, 32'h44332211);
        apb(1, OFF_TX_LEN, 32'h4);
        apb(1, OFF_TX_PARAMS, 32'h05000100);
        apb(0, OFF_TX_PARAMS, 0);
        ck(rd, 32'h05000100);
        apb(1, OFF_CTRL_SET, 32'h1);
        apb(1, OFF_CHAN_TIME, 32'hFF);
        wait_frames(1);
        ck(u_radio_sink.rx_q.size(), 8);
        for (int k = 0; k < 4; k++) ck(u_radio_sink.rx_q[k], 8'h11 * (k + 1));
        ck({u_radio_sink.rx_q[7], u_radio_sink.rx_q[6], u_radio_sink.rx_q[5],
            u_radio_sink.rx_q[4]}, fcs(32'h44332211));
        ck(irq, 0);
        apb(1, OFF_INT_MASK, 32'h1);
        @(negedge clk);
        ck(irq, 1);
        apb(1, OFF_INT_STAT, 32'h1);
        @(negedge clk);
        ck(irq, 0);
        apb(1, OFF_TX_ADJ_IE, 32'h9);
        apb(1, OFF_CHAN_TIME, 32'h010104);
        wait_frames(2);
        apb(1, OFF_CHAN_TIME, 32'h02010D);
        wait_frames(3);
    endtask

    task automatic t_off;
        for (int i = 0; i < 3; i++) begin
            apb(1, OFF_CTRL_SET, 32'h1);
            apb(0, OFF_STATUS, 0);
            ck(rd[0], 1);
            @(posedge clk);
            slp <= (i == 0);
            auth <= (i != 1);
            @(posedge clk);
            slp <= 0;
            auth <= 1;
            if (i == 2) apb(1, OFF_CTRL_CLR, 32'h1);
            apb(0, OFF_STATUS, 0);
            ck(rd[0], 0);
        end
    endtask

    task automatic t_rx;
        apb(1, OFF_RX_START, 32'h200);
        apb(1, OFF_RX_END, 32'h300);
        apb(1, OFF_RX_CFG, 32'h0822);
        apb(1, OFF_CTRL_SET, 32'h2);
        apb(1, OFF_CHAN_TIME, 32'h1FF);
        wait_en(1);
        ck(rx_ch, 8'h22);
        apb(1, OFF_CHAN_TIME, 32'h250);
        pkt(48'h665544332218, 8'h5A);
        pkt(48'h665544332210, 8'h5A);
        apb(0, OFF_STATUS, 0);
        ck(rd, 32'h0106);
        apb(0, OFF_LOG, 0);
        ck(rd, 32'h5A000250);
        apb(0, 10'h204, 0);
        ck(rd, 32'h44332218);
        apb(1, OFF_CHAN_TIME, 32'h2FF);
        wait_en(0);
        pkt(48'h665544332218, 8'h5A);
        apb(0, OFF_STATUS, 0);
        ck(rd, 32'h0100);
        apb(1, OFF_CTRL_SET, 32'h2);
        apb(1, OFF_CHAN_TIME, 32'h1FF);
        wait_en(1);
        repeat (32) pkt(48'h0000AABB0018, 8'h01);
        apb(0, OFF_STATUS, 0);
        ck(rd, 32'h2008);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1;
        apb(0, OFF_STATUS, 0);
        ck(rd, 0);
        apb(0, 10'h030, 0);
        ck(err, 1);
        t_tx;
        t_off;
        t_rx;
        wrap_up;
    end

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
endmodule
